/* src/mpp_consts.svh */
// Offsets, field positions, reset values and limits of the parameter register bank
`ifndef MPP_CONSTS_SVH
`define MPP_CONSTS_SVH

// ==================================================
// Register offsets
`define MPP_OFS_PFC_RUN      16'h819c
`define MPP_OFS_BLANK_OFS    16'h81aa
`define MPP_OFS_D_FF         16'h81e4
`define MPP_OFS_PFC_BUS_REF  16'h8252
`define MPP_OFS_CRIT_OV      16'h8274
`define MPP_OFS_BUS_OV       16'h8276
`define MPP_OFS_BUS_UV       16'h8278
`define MPP_OFS_ADC_HI       16'h82a8
`define MPP_OFS_ADC_LO       16'h82aa
`define MPP_OFS_VF_FREQ      16'h82bc
`define MPP_OFS_VF_GAIN      16'h82be
`define MPP_OFS_ZERO_REQ     16'h8326
`define MPP_OFS_PFC_IREF     16'h832c
`define MPP_OFS_EXT_REV      16'h838e
`define MPP_OFS_EXT_FWD      16'h8396
`define MPP_OFS_FLX_BETA     16'h839a
`define MPP_OFS_FLX_ALPHA    16'h839c
`define MPP_OFS_Q_FF         16'h839e
`define MPP_OFS_KILL_CNT     16'hf1d8

// ==================================================
// Reset values, limits, scale shifts and field positions
`define MPP_RST_ZERO         16'h0000
`define MPP_RST_KILL_CNT     16'h0013
`define MPP_BUS_UNIT_SHIFT   4
`define MPP_FF_LIMIT         18'sh00596
`define MPP_VF_SHIFT         8
`define MPP_VF_FREQ_MAX      16'h4000
`define MPP_KILL_LSB         0
`define MPP_KILL_MSB         7

`endif

/* src/mpp_pkg.sv */
// Types shared by the parameter register bank
package mpp_pkg;

    // ==================================================
    // Register slots of the bank
    typedef enum logic [4:0] {
        MPP_PFC_RUN, MPP_BLANK_OFS, MPP_D_FF, MPP_PFC_BUS_REF, MPP_CRIT_OV,
        MPP_BUS_OV, MPP_BUS_UV, MPP_ADC_HI, MPP_ADC_LO, MPP_VF_FREQ,
        MPP_VF_GAIN, MPP_ZERO_REQ, MPP_PFC_IREF, MPP_EXT_REV, MPP_EXT_FWD,
        MPP_FLX_BETA, MPP_FLX_ALPHA, MPP_Q_FF, MPP_KILL_CNT, MPP_NONE
    } mpp_reg_idx_t;

endpackage : mpp_pkg

/* src/mpp_param_regs.sv */
// Parameter register bank with protection, injection and PFC gating logic
`timescale 1ns/1ps
`include "mpp_consts.svh"

module mpp_param_regs
    import mpp_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    // Register port of the on-chip controller
    input  wire logic [15:0]        reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [15:0]        reg_rdata,
    // Control cycle boundary and fault clear
    input  wire logic               ctrl_cycle,
    input  wire logic               fault_clear,
    // Measured quantities from the converter path
    input  wire logic [11:0]        dc_bus_volts,
    input  wire logic [11:0]        ac_volts,
    // Regulator and estimator signals
    input  wire logic [11:0]        fwd_angle_in,
    input  wire logic [11:0]        rev_angle_in,
    input  wire logic               external_flux_select,
    input  wire logic signed [15:0] est_flux_alpha,
    input  wire logic signed [15:0] est_flux_beta,
    input  wire logic signed [15:0] d_reg_out,
    input  wire logic signed [15:0] q_reg_out,
    input  wire logic [14:0]        d_output_limit,
    input  wire logic [14:0]        q_output_limit,
    // PFC side inputs
    input  wire logic               pfc_allow,
    input  wire logic               pfc_kill_input,
    input  wire logic [9:0]         pfc_blank_hysteresis,
    // Protection outputs
    output logic                    low_side_clamp,
    output logic                    crit_ov_fault,
    output logic                    bus_ov_fault,
    output logic                    bus_uv_fault,
    // Injection outputs
    output logic      [11:0]        fwd_angle_out,
    output logic      [11:0]        rev_angle_out,
    output logic signed [15:0]      flux_alpha_out,
    output logic signed [15:0]      flux_beta_out,
    output logic signed [15:0]      d_mod_out,
    output logic signed [15:0]      q_mod_out,
    // Compensation and diagnostic outputs
    output logic      [11:0]        adc_ref_high_out,
    output logic      [11:0]        adc_ref_low_out,
    output logic      [15:0]        vf_mod_index,
    output logic      [15:0]        vf_freq_out,
    // PFC outputs
    output logic      [11:0]        pfc_current_cmd,
    output logic                    pfc_voltage_blank_flag,
    output logic                    pfc_kill_fault,
    output logic                    pfc_pwm_enable
);

    // ==================================================
    // Decode helpers
    // Map an address to its register slot; used by write and read paths
    function automatic mpp_reg_idx_t reg_index(input logic [15:0] a);
        unique case (a)
            `MPP_OFS_PFC_RUN:     reg_index = MPP_PFC_RUN;
            `MPP_OFS_BLANK_OFS:   reg_index = MPP_BLANK_OFS;
            `MPP_OFS_D_FF:        reg_index = MPP_D_FF;
            `MPP_OFS_PFC_BUS_REF: reg_index = MPP_PFC_BUS_REF;
            `MPP_OFS_CRIT_OV:     reg_index = MPP_CRIT_OV;
            `MPP_OFS_BUS_OV:      reg_index = MPP_BUS_OV;
            `MPP_OFS_BUS_UV:      reg_index = MPP_BUS_UV;
            `MPP_OFS_ADC_HI:      reg_index = MPP_ADC_HI;
            `MPP_OFS_ADC_LO:      reg_index = MPP_ADC_LO;
            `MPP_OFS_VF_FREQ:     reg_index = MPP_VF_FREQ;
            `MPP_OFS_VF_GAIN:     reg_index = MPP_VF_GAIN;
            `MPP_OFS_ZERO_REQ:    reg_index = MPP_ZERO_REQ;
            `MPP_OFS_PFC_IREF:    reg_index = MPP_PFC_IREF;
            `MPP_OFS_EXT_REV:     reg_index = MPP_EXT_REV;
            `MPP_OFS_EXT_FWD:     reg_index = MPP_EXT_FWD;
            `MPP_OFS_FLX_BETA:    reg_index = MPP_FLX_BETA;
            `MPP_OFS_FLX_ALPHA:   reg_index = MPP_FLX_ALPHA;
            `MPP_OFS_Q_FF:        reg_index = MPP_Q_FF;
            `MPP_OFS_KILL_CNT:    reg_index = MPP_KILL_CNT;
            default:              reg_index = MPP_NONE;
        endcase
    endfunction : reg_index

    // Saturate a sum to plus or minus a limit
    function automatic logic signed [15:0] sat_lim(input logic signed [17:0] v,
                                                   input logic signed [17:0] lim);
        if (v > lim) begin
            sat_lim = lim[15:0];
        end else if (v < -lim) begin
            sat_lim = 16'((-lim));
        end else begin
            sat_lim = v[15:0];
        end
    endfunction : sat_lim

    // ==================================================
    // Register storage
    localparam int NREG = 19;
    logic [15:0]  live [NREG];     // Value firmware sees
    logic [15:0]  act  [NREG];     // Value the datapath uses
    mpp_reg_idx_t wr_idx;          // Slot hit by the current write
    mpp_reg_idx_t rd_idx;          // Slot hit by the current read

    assign wr_idx = reg_index(reg_addr);
    assign rd_idx = reg_index(reg_addr);

    // One writer and one shadow per slot; live takes writes, act takes live at the
    // cycle boundary so no computation sees a value change midway
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        localparam logic [15:0] RST = (i == int'(MPP_KILL_CNT)) ? `MPP_RST_KILL_CNT
                                                                 : `MPP_RST_ZERO;
        // Firmware write
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                live[i] <= RST;
            end else if (reg_wr && (int'(wr_idx) == i)) begin
                live[i] <= reg_wdata;
            end
        end
        // Apply at the next control cycle
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                act[i] <= RST;
            end else if (ctrl_cycle) begin
                act[i] <= live[i];
            end
        end
    end

    // Read path: mapped slots return firmware value, others zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= (rd_idx == MPP_NONE) ? 16'h0000 : live[rd_idx];
        end
    end

    // ==================================================
    // Dc bus protection
    logic [15:0] bus_ext;    // Feedback zero-extended to threshold width
    logic [15:0] crit_thr;   // Thresholds scaled by sixteen
    logic [15:0] ov_thr;
    logic [15:0] uv_thr;

    assign bus_ext  = {4'h0, dc_bus_volts};
    assign crit_thr = act[MPP_CRIT_OV] << `MPP_BUS_UNIT_SHIFT;
    assign ov_thr   = act[MPP_BUS_OV] << `MPP_BUS_UNIT_SHIFT;
    assign uv_thr   = act[MPP_BUS_UV] << `MPP_BUS_UNIT_SHIFT;

    // Critical trip latches; a new trip wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            crit_ov_fault <= 1'b0;
        end else if (bus_ext > crit_thr) begin
            crit_ov_fault <= 1'b1;
        end else if (fault_clear) begin
            crit_ov_fault <= 1'b0;
        end
    end

    // Braking rides on the latch, so a falling bus does not release it
    assign low_side_clamp = crit_ov_fault;

    // Overvoltage and undervoltage faults, sticky until cleared
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_ov_fault <= 1'b0;
        end else if (bus_ext > ov_thr) begin
            bus_ov_fault <= 1'b1;
        end else if (fault_clear) begin
            bus_ov_fault <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_uv_fault <= 1'b0;
        end else if (bus_ext < uv_thr) begin
            bus_uv_fault <= 1'b1;
        end else if (fault_clear) begin
            bus_uv_fault <= 1'b0;
        end
    end

    // ==================================================
    // Angle, flux and feedforward injection
    logic [11:0]        fwd_sum;    // Angles wrap at a full turn
    logic [11:0]        rev_sum;
    logic signed [15:0] d_ff_lim;   // Feedforward held inside full modulation
    logic signed [15:0] q_ff_lim;

    assign fwd_sum  = fwd_angle_in + act[MPP_EXT_FWD][11:0];
    assign rev_sum  = rev_angle_in + act[MPP_EXT_REV][11:0];
    assign d_ff_lim = sat_lim(18'(signed'(act[MPP_D_FF])), `MPP_FF_LIMIT);
    assign q_ff_lim = sat_lim(18'(signed'(act[MPP_Q_FF])), `MPP_FF_LIMIT);

    // Angles and fluxes registered for the regulator
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fwd_angle_out  <= 12'h000;
            rev_angle_out  <= 12'h000;
            flux_alpha_out <= 16'sh0000;
            flux_beta_out  <= 16'sh0000;
        end else begin
            fwd_angle_out <= fwd_sum;
            rev_angle_out <= rev_sum;
            if (external_flux_select) begin
                flux_alpha_out <= signed'(act[MPP_FLX_ALPHA]);
                flux_beta_out  <= signed'(act[MPP_FLX_BETA]);
            end else begin
                flux_alpha_out <= est_flux_alpha;
                flux_beta_out  <= est_flux_beta;
            end
        end
    end

    // D and q outputs: zero request overrides the normal limits
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            d_mod_out <= 16'sh0000;
            q_mod_out <= 16'sh0000;
        end else if (act[MPP_ZERO_REQ][0]) begin
            d_mod_out <= 16'sh0000;
            q_mod_out <= 16'sh0000;
        end else begin
            d_mod_out <= sat_lim(18'(d_reg_out) + 18'(d_ff_lim),
                                 18'(signed'({1'b0, d_output_limit})));
            q_mod_out <= sat_lim(18'(q_reg_out) + 18'(q_ff_lim),
                                 18'(signed'({1'b0, q_output_limit})));
        end
    end

    // ==================================================
    // Compensation references and open-loop diagnostic
    logic [15:0] vf_freq_lim;   // Frequency held inside its range
    logic [23:0] vf_prod;       // Gain times frequency before scaling

    assign vf_freq_lim = (act[MPP_VF_FREQ] > `MPP_VF_FREQ_MAX) ? `MPP_VF_FREQ_MAX
                                                               : act[MPP_VF_FREQ];
    assign vf_prod     = act[MPP_VF_GAIN][7:0] * vf_freq_lim;

    // Registered so downstream sees only whole-cycle values
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            adc_ref_high_out <= 12'h000;
            adc_ref_low_out  <= 12'h000;
            vf_mod_index     <= 16'h0000;
            vf_freq_out      <= 16'h0000;
            pfc_current_cmd  <= 12'h000;
        end else begin
            adc_ref_high_out <= act[MPP_ADC_HI][11:0];
            adc_ref_low_out  <= act[MPP_ADC_LO][11:0];
            vf_mod_index     <= vf_prod[23:`MPP_VF_SHIFT];
            vf_freq_out      <= vf_freq_lim;
            pfc_current_cmd  <= act[MPP_PFC_IREF][11:0];
        end
    end

    // ==================================================
    // PFC gate-kill filter
    logic [2:0] kill_sync;     // Three-stage synchroniser on the pin
    logic       kill_stable;   // Level accepted once stages two and three agree
    logic [7:0] kill_cnt;      // Consecutive asserted cycles, saturating
    logic [7:0] kill_filt;     // Low byte only; upper bits are firmware's duty

    assign kill_filt = act[MPP_KILL_CNT][`MPP_KILL_MSB:`MPP_KILL_LSB];

    // Synchroniser; stage one feeds stage two only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            kill_sync <= 3'h0;
        end else begin
            kill_sync <= {kill_sync[1:0], pfc_kill_input};
        end
    end

    // Accept a change only when the later stages match
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            kill_stable <= 1'b0;
        end else if (kill_sync[1] == kill_sync[2]) begin
            kill_stable <= kill_sync[2];
        end
    end

    // Persistence counter; any release restarts it so noise never accumulates
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            kill_cnt <= 8'h00;
        end else if (!kill_stable) begin
            kill_cnt <= 8'h00;
        end else if (kill_cnt != 8'hff) begin
            kill_cnt <= kill_cnt + 8'h01;
        end
    end

    // Latched shutdown; a new trip wins over a clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pfc_kill_fault <= 1'b0;
        end else if (kill_stable && (kill_cnt >= kill_filt)) begin
            pfc_kill_fault <= 1'b1;
        end else if (fault_clear) begin
            pfc_kill_fault <= 1'b0;
        end
    end

    // ==================================================
    // PFC voltage blanking with hysteresis
    logic signed [13:0] blank_on;    // Trip point
    logic signed [13:0] blank_off;   // Release point, one gap lower

    assign blank_on  = 14'(act[MPP_PFC_BUS_REF][11:1]) - 14'(act[MPP_BLANK_OFS][9:0])
                     - 14'(pfc_blank_hysteresis);
    assign blank_off = blank_on - 14'(pfc_blank_hysteresis);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pfc_voltage_blank_flag <= 1'b0;
        end else if (signed'(14'(ac_volts)) > blank_on) begin
            pfc_voltage_blank_flag <= 1'b1;
        end else if (signed'(14'(ac_volts)) < blank_off) begin
            pfc_voltage_blank_flag <= 1'b0;
        end
    end

    // Top-level PFC gate: switch, state machine, blanking and kill all agree
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pfc_pwm_enable <= 1'b0;
        end else begin
            pfc_pwm_enable <= act[MPP_PFC_RUN][0]
                              && pfc_allow
                              && !pfc_voltage_blank_flag
                              && !pfc_kill_fault;
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    crit_clamp_hold_a: assert property (crit_ov_fault && !fault_clear && !$past(sys_rst)
        |=> low_side_clamp)
        else $error("critical clamp released without clear");
    crit_trip_a: assert property (bus_ext > crit_thr |=> low_side_clamp)
        else $error("critical trip missed");
    bus_ov_trip_a: assert property (bus_ext > ov_thr |=> bus_ov_fault)
        else $error("overvoltage fault missed");
    bus_uv_trip_a: assert property (bus_ext < uv_thr |=> bus_uv_fault)
        else $error("undervoltage fault missed");
    zero_request_a: assert property (act[MPP_ZERO_REQ][0]
        |=> d_mod_out == 16'sh0000 && q_mod_out == 16'sh0000)
        else $error("zero request did not null outputs");
    fwd_angle_a: assert property (!sys_rst |=> fwd_angle_out
        == 12'($past(fwd_angle_in) + $past(act[MPP_EXT_FWD][11:0])))
        else $error("forward angle sum wrong");
    kill_persist_a: assert property ($rose(pfc_kill_fault)
        |-> $past(kill_stable) && $past(kill_cnt) >= $past(kill_filt))
        else $error("kill fault without persistence");
    pfc_veto_a: assert property (!pfc_allow |=> !pfc_pwm_enable)
        else $error("pfc ran against state machine");
    apply_hold_a: assert property (!ctrl_cycle |=> $stable(act[MPP_ZERO_REQ]))
        else $error("parameter changed mid cycle");
    unmapped_read_a: assert property (reg_rd && rd_idx == MPP_NONE
        |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");

endmodule : mpp_param_regs

/* verification/mpp_fw_model.sv */
// Firmware stand-in that writes, reads and applies bank parameters
`timescale 1ns/1ps
`include "mpp_consts.svh"

module mpp_fw_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] reg_rdata,
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             ctrl_cycle
);
    // Idle bus from time zero so no strobe floats during reset
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, ctrl_cycle} = '0;
    end

    // One-cycle write strobe; an idle cycle follows so strobes never merge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Kill count goes in the low byte, upper byte always zero
    task automatic wr_kill(input logic [7:0] n);
        wr(`MPP_OFS_KILL_CNT, {8'h00, n});
    endtask : wr_kill

    // Read strobe, then data is taken one edge later
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask : rd

    // Control-cycle boundary that copies written live values into act for the datapath
    task automatic apply();
        @(posedge core_clk);
        ctrl_cycle <= 1'b1;
        @(posedge core_clk);
        ctrl_cycle <= 1'b0;
    endtask : apply
endmodule : mpp_fw_model

/* verification/mpp_param_regs_tb.sv */
// Self-checking bench for the parameter register bank
`timescale 1ns/1ps
`include "mpp_consts.svh"

module mpp_param_regs_tb import mpp_pkg::*; ;
    logic               core_clk, sys_rst, fault_clear, external_flux_select;
    logic               pfc_allow, pfc_kill_input, reg_wr, reg_rd, ctrl_cycle;
    logic        [15:0] reg_addr, reg_wdata, reg_rdata, vf_mod_index, vf_freq_out, v;
    logic        [11:0] dc_bus_volts, ac_volts, fwd_angle_in, rev_angle_in;
    logic        [11:0] fwd_angle_out, rev_angle_out, adc_ref_high_out, adc_ref_low_out;
    logic        [11:0] pfc_current_cmd;
    logic signed [15:0] est_flux_alpha, est_flux_beta, d_reg_out, q_reg_out;
    logic signed [15:0] flux_alpha_out, flux_beta_out, d_mod_out, q_mod_out;
    logic        [14:0] d_output_limit, q_output_limit;
    logic        [9:0]  pfc_blank_hysteresis;
    logic               low_side_clamp, crit_ov_fault, bus_ov_fault, bus_uv_fault;
    logic               pfc_voltage_blank_flag, pfc_kill_fault, pfc_pwm_enable;
    int                 miscompares, comparisons;

    mpp_param_regs u_dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ctrl_cycle, .fault_clear, .dc_bus_volts, .ac_volts, .fwd_angle_in,
        .rev_angle_in, .external_flux_select, .est_flux_alpha, .est_flux_beta, .d_reg_out,
        .q_reg_out, .d_output_limit, .q_output_limit, .pfc_allow, .pfc_kill_input,
        .pfc_blank_hysteresis, .low_side_clamp, .crit_ov_fault, .bus_ov_fault, .bus_uv_fault,
        .fwd_angle_out, .rev_angle_out, .flux_alpha_out, .flux_beta_out, .d_mod_out,
        .q_mod_out, .adc_ref_high_out, .adc_ref_low_out, .vf_mod_index, .vf_freq_out,
        .pfc_current_cmd, .pfc_voltage_blank_flag, .pfc_kill_fault, .pfc_pwm_enable);
    mpp_fw_model fw (.core_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .ctrl_cycle);

    // ==========================================
    // Helpers
    // Case inequality so an unknown never counts as a match
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Let registered outputs land, then sample clear of the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // Clear pulse; a trip still present would win over it
    task automatic clear_faults();
        @(posedge core_clk);
        fault_clear <= 1'b1;
        @(posedge core_clk);
        fault_clear <= 1'b0;
        tick(2);
    endtask : clear_faults

    task automatic set_dc(input logic [11:0] x);
        @(posedge core_clk);
        dc_bus_volts <= x;
        tick(3);
    endtask : set_dc

    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================
    // Scenarios
    // Reset values, unmapped read, live readback
    task automatic t_regs();
        fw.rd(`MPP_OFS_KILL_CNT, v);
        check(v, 16'h0013);
        fw.rd(`MPP_OFS_PFC_RUN, v);
        check(v, 16'h0000);
        fw.rd(16'h8000, v);
        check(v, 16'h0000);
        fw.wr(`MPP_OFS_Q_FF, 16'h1234);
        fw.rd(`MPP_OFS_Q_FF, v);
        check(v, 16'h1234);
        $display("register test done");
    endtask : t_regs

    // Undervoltage and overvoltage levels at their exact boundaries, critical level just above its own, in units of 16 counts
    task automatic t_bus();
        fw.wr(`MPP_OFS_CRIT_OV, 16'h0020);
        fw.wr(`MPP_OFS_BUS_OV, 16'h0010);
        fw.wr(`MPP_OFS_BUS_UV, 16'h0008);
        set_dc(12'h07f);
        check(bus_uv_fault, 1'b0);
        fw.apply();
        tick(3);
        check(bus_uv_fault, 1'b1);
        set_dc(12'h080);
        clear_faults();
        check(bus_uv_fault, 1'b0);
        set_dc(12'h100);
        check(bus_ov_fault, 1'b0);
        set_dc(12'h101);
        check(bus_ov_fault, 1'b1);
        check(crit_ov_fault, 1'b0);
        set_dc(12'h201);
        check(low_side_clamp, 1'b1);
        set_dc(12'h0c0);
        check(low_side_clamp, 1'b1);
        clear_faults();
        check(low_side_clamp, 1'b0);
        $display("bus test done");
    endtask : t_bus

    // Injection paths, saturation, flux swap and zero request
    task automatic t_inject();
        fw.wr(`MPP_OFS_D_FF, 16'h07d0);
        fw.wr(`MPP_OFS_Q_FF, 16'hf830);
        fw.wr(`MPP_OFS_EXT_FWD, 16'h0c00);
        fw.wr(`MPP_OFS_EXT_REV, 16'h0400);
        fw.wr(`MPP_OFS_FLX_ALPHA, 16'hec78);
        fw.wr(`MPP_OFS_FLX_BETA, 16'h1388);
        fw.wr(`MPP_OFS_ADC_HI, 16'h0fff);
        fw.wr(`MPP_OFS_ADC_LO, 16'h0155);
        fw.wr(`MPP_OFS_VF_GAIN, 16'h0080);
        fw.wr(`MPP_OFS_VF_FREQ, 16'h03e8);
        fw.wr(`MPP_OFS_PFC_IREF, 16'h0abc);
        fw.apply();
        tick(3);
        check(d_mod_out, 16'h05fa);
        check(q_mod_out, 16'hfa6a);
        check(fwd_angle_out, 12'h100);
        check(rev_angle_out, 12'h410);
        check(flux_alpha_out, 16'hec78);
        check(flux_beta_out, 16'h1388);
        check(adc_ref_high_out, 12'hfff);
        check(adc_ref_low_out, 12'h155);
        check(vf_mod_index, 16'h01f4);
        check(vf_freq_out, 16'h03e8);
        check(pfc_current_cmd, 12'habc);
        @(posedge core_clk);
        external_flux_select <= 1'b0;
        tick(3);
        check(flux_alpha_out, 16'h0007);
        check(flux_beta_out, 16'h0007);
        fw.wr(`MPP_OFS_ZERO_REQ, 16'h0001);
        fw.apply();
        tick(3);
        check(d_mod_out, 16'h0000);
        check(q_mod_out, 16'h0000);
        fw.wr(`MPP_OFS_ZERO_REQ, 16'h0000);
        fw.apply();
        tick(3);
        check(d_mod_out, 16'h05fa);
        // Normal output limit clips the regulator sum again
        @(posedge core_clk);
        d_output_limit <= 15'h0200;
        tick(3);
        check(d_mod_out, 16'h0200);
        // Frequency beyond its range is held at the top count
        fw.wr(`MPP_OFS_VF_FREQ, 16'h5000);
        fw.apply();
        tick(3);
        check(vf_freq_out, 16'h4000);
        check(vf_mod_index, 16'h2000);
        $display("injection test done");
    endtask : t_inject

    // Run switch, state machine veto, blanking and kill filter
    task automatic t_pfc();
        fw.wr(`MPP_OFS_PFC_BUS_REF, 16'h0800);
        fw.wr(`MPP_OFS_BLANK_OFS, 16'h0010);
        fw.wr(`MPP_OFS_PFC_RUN, 16'h0001);
        fw.wr_kill(8'h05);
        fw.apply();
        tick(3);
        check(pfc_pwm_enable, 1'b1);
        @(posedge core_clk);
        pfc_allow <= 1'b0;
        tick(3);
        check(pfc_pwm_enable, 1'b0);
        @(posedge core_clk);
        pfc_allow <= 1'b1;
        ac_volts  <= 12'h3e9;
        tick(3);
        check(pfc_voltage_blank_flag, 1'b1);
        check(pfc_pwm_enable, 1'b0);
        // Inside the hysteresis band the flag keeps its state
        @(posedge core_clk);
        ac_volts <= 12'h3d8;
        tick(3);
        check(pfc_voltage_blank_flag, 1'b1);
        @(posedge core_clk);
        ac_volts <= 12'h000;
        tick(3);
        check(pfc_voltage_blank_flag, 1'b0);
        // Two-sample glitch on the pin must not reach the latch
        @(posedge core_clk);
        pfc_kill_input <= 1'b1;
        repeat (2) @(posedge core_clk);
        pfc_kill_input <= 1'b0;
        tick(8);
        check(pfc_kill_fault, 1'b0);
        @(posedge core_clk);
        pfc_kill_input <= 1'b1;
        tick(16);
        check(pfc_kill_fault, 1'b1);
        check(pfc_pwm_enable, 1'b0);
        @(posedge core_clk);
        pfc_kill_input <= 1'b0;
        tick(6);
        clear_faults();
        tick(1);
        check(pfc_pwm_enable, 1'b1);
        $display("pfc test done");
    endtask : t_pfc

    // ==========================================
    // Clock, watchdog and main sequence
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Whole run is well under a thousand cycles; this is ample margin
    initial begin
        #(100 * 20000);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        {sys_rst, fault_clear, pfc_kill_input, dc_bus_volts, ac_volts} = '0;
        {fwd_angle_in, rev_angle_in} = {12'h500, 12'h010};
        {est_flux_alpha, est_flux_beta} = {16'sh0007, 16'sh0007};
        {d_reg_out, q_reg_out} = {16'sh0064, 16'sh0000};
        {d_output_limit, q_output_limit} = {15'h7fff, 15'h7fff};
        {external_flux_select, pfc_allow, pfc_blank_hysteresis} = {1'b1, 1'b1, 10'h010};
        sys_rst = 1'b1;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_bus();
        t_inject();
        t_pfc();
        tally_and_finish();
    end
endmodule : mpp_param_regs_tb
